// *** pfs_regulator.sv ***
/*
  Regulator front end with APB register access: reference and feedback
  selection, analog scaling, deadband, integrator preload, trim limits and
  the frequency command toward the drive path.
  Assumes one 100 MHz clock, APB master on the same clock, sensor and network
  words arriving from outside the clock domain.
*/
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
module pfs_regulator
  import pfs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] i_analog_one,
  input  wire logic [15:0] i_analog_two,
  input  wire logic [15:0] i_actual_one,
  input  wire logic [15:0] i_actual_two,
  input  wire logic [15:0] i_comm_word,
  input  wire logic [15:0] i_speed_ref,
  input  wire logic        i_run,
  output logic      [15:0] o_freq_cmd,
  output logic      [15:0] o_error,
  output logic             o_regulating
);

  localparam int SW = 97;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (i_ce) begin
      sync_a <= {i_run, i_speed_ref, i_comm_word, i_actual_two, i_actual_one,
                 i_analog_two, i_analog_one};
      sync_b <= sync_a;
    end
  end

  logic signed [15:0] an_one;
  logic signed [15:0] an_two;
  logic signed [15:0] act_one;
  logic signed [15:0] act_two;
  logic signed [15:0] comm_word;
  logic signed [15:0] speed_ref;
  logic               run_s;

  assign an_one    = sync_b[15:0];
  assign an_two    = sync_b[31:16];
  assign act_one   = sync_b[47:32];
  assign act_two   = sync_b[63:48];
  assign comm_word = sync_b[79:64];
  assign speed_ref = sync_b[95:80];
  assign run_s     = sync_b[96];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]  reference_source_select;
  logic [3:0]  feedback_source_select;
  logic        enable;
  logic [15:0] analog_one_low_point;
  logic [15:0] analog_one_high_point;
  logic [15:0] analog_two_low_point;
  logic [15:0] analog_two_high_point;
  logic [15:0] setpoint;
  logic [15:0] error_deadband;
  logic [15:0] integrator_preload;
  logic [15:0] prop_gain;
  logic [15:0] integ_gain;
  logic [15:0] trim_hi;
  logic [15:0] trim_lo;
  logic [15:0] maximum_frequency_setting;
  logic signed [15:0] feedback;
  logic        at_limit;
  pfs_state_e  state;

  logic apb_access;
  logic apb_done;
  logic addr_ok;

  assign apb_access = psel && penable;
  assign apb_done   = apb_access && pready;

  always_comb begin
    case (paddr)
      REG_CTRL, REG_AN1_LO, REG_AN1_HI, REG_AN2_LO, REG_AN2_HI, REG_SETPOINT,
      REG_DEADBAND, REG_PRELOAD, REG_KP, REG_KI, REG_TRIM_HI, REG_TRIM_LO,
      REG_MAX_FREQ, REG_STAT_FB, REG_STAT_ERR, REG_STAT_CMD, REG_STATUS:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // one wait state, answer on the second access edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (i_ce) begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_ok;
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          REG_CTRL:     prdata <= {23'h0, enable, feedback_source_select,
                                   reference_source_select};
          REG_AN1_LO:   prdata <= {16'h0, analog_one_low_point};
          REG_AN1_HI:   prdata <= {16'h0, analog_one_high_point};
          REG_AN2_LO:   prdata <= {16'h0, analog_two_low_point};
          REG_AN2_HI:   prdata <= {16'h0, analog_two_high_point};
          REG_SETPOINT: prdata <= {16'h0, setpoint};
          REG_DEADBAND: prdata <= {16'h0, error_deadband};
          REG_PRELOAD:  prdata <= {16'h0, integrator_preload};
          REG_KP:       prdata <= {16'h0, prop_gain};
          REG_KI:       prdata <= {16'h0, integ_gain};
          REG_TRIM_HI:  prdata <= {16'h0, trim_hi};
          REG_TRIM_LO:  prdata <= {16'h0, trim_lo};
          REG_MAX_FREQ: prdata <= {16'h0, maximum_frequency_setting};
          REG_STAT_FB:  prdata <= {16'h0, feedback};
          REG_STAT_ERR: prdata <= {16'h0, o_error};
          REG_STAT_CMD: prdata <= {16'h0, o_freq_cmd};
          REG_STATUS:   prdata <= {29'h0, at_limit, state};
          default:      prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reference_source_select   <= RST_SEL;
      feedback_source_select    <= RST_SEL;
      enable                    <= 1'b0;
      analog_one_low_point      <= RST_AN_LO;
      analog_one_high_point     <= RST_AN_HI;
      analog_two_low_point      <= RST_AN_LO;
      analog_two_high_point     <= RST_AN_HI;
      setpoint                  <= RST_ZERO16;
      error_deadband            <= RST_ZERO16;
      integrator_preload        <= RST_ZERO16;
      prop_gain                 <= RST_KP;
      integ_gain                <= RST_ZERO16;
      trim_hi                   <= RST_ZERO16;
      trim_lo                   <= RST_ZERO16;
      maximum_frequency_setting <= RST_MAX_FREQ;
    end else if (i_ce && apb_done && pwrite) begin
      case (paddr)
        REG_CTRL: begin
          reference_source_select <= pwdata[CTRL_REF_LSB +: 4];
          feedback_source_select  <= pwdata[CTRL_FB_LSB +: 4];
          enable                  <= pwdata[CTRL_EN_BIT];
        end
        REG_AN1_LO:   analog_one_low_point      <= pwdata[15:0];
        REG_AN1_HI:   analog_one_high_point     <= pwdata[15:0];
        REG_AN2_LO:   analog_two_low_point      <= pwdata[15:0];
        REG_AN2_HI:   analog_two_high_point     <= pwdata[15:0];
        REG_SETPOINT: setpoint                  <= pwdata[15:0];
        REG_DEADBAND: error_deadband            <= pwdata[15:0];
        REG_PRELOAD:  integrator_preload        <= pwdata[15:0];
        REG_KP:       prop_gain                 <= pwdata[15:0];
        REG_KI:       integ_gain                <= pwdata[15:0];
        REG_TRIM_HI:  trim_hi                   <= pwdata[15:0];
        REG_TRIM_LO:  trim_lo                   <= pwdata[15:0];
        REG_MAX_FREQ: maximum_frequency_setting <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference and feedback paths
  logic signed [15:0] ref_an_one;
  logic signed [15:0] ref_an_two;
  logic signed [15:0] an_two_pos;
  logic signed [15:0] comm_pct;
  logic signed [15:0] fb_sel;
  logic signed [15:0] reference;

  assign an_two_pos = (an_two < PCT_ZERO) ? PCT_ZERO : an_two;

  pfs_scale u_scale_one (
    .i_in  (an_one),
    .i_lo  (analog_one_low_point),
    .i_hi  (analog_one_high_point),
    .o_pct (ref_an_one)
  );

  pfs_scale u_scale_two (
    .i_in  (an_two_pos),
    .i_lo  (analog_two_low_point),
    .i_hi  (analog_two_high_point),
    .o_pct (ref_an_two)
  );

  pfs_fb_mux u_fb_mux (
    .i_sel        (feedback_source_select),
    .i_an_one     (an_one),
    .i_an_two     (an_two),
    .i_comm_word  (comm_word),
    .i_max_freq   (maximum_frequency_setting),
    .i_actual_one (act_one),
    .i_actual_two (act_two),
    .o_fb         (fb_sel)
  );

  // network word as a reference uses the same percent scaling
  pfs_fb_mux u_ref_comm (
    .i_sel        (FB_COMM),
    .i_an_one     (PCT_ZERO),
    .i_an_two     (PCT_ZERO),
    .i_comm_word  (comm_word),
    .i_max_freq   (maximum_frequency_setting),
    .i_actual_one (PCT_ZERO),
    .i_actual_two (PCT_ZERO),
    .o_fb         (comm_pct)
  );

  always_comb begin
    case (reference_source_select)
      REF_SETPT, REF_SETPT_TRIM: reference = setpoint;
      REF_AN1, REF_AN1_TRIM:     reference = ref_an_one;
      REF_AN2, REF_AN2_TRIM:     reference = ref_an_two;
      REF_COMM, REF_COMM_TRIM:   reference = comm_pct;
      default:                   reference = PCT_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // error, deadband and PI terms
  logic               trim_mode;
  logic               active;
  logic signed [31:0] err_raw;
  logic signed [31:0] err;
  logic signed [31:0] err_abs;
  logic signed [31:0] lim_hi;
  logic signed [31:0] lim_lo;
  logic signed [47:0] p_term;
  logic signed [47:0] acc;
  logic signed [47:0] pid_raw;
  logic signed [31:0] pid;
  logic signed [47:0] max_tenths;

  assign trim_mode  = (reference_source_select >= REF_SETPT_TRIM)
                   && (reference_source_select <= REF_COMM_TRIM);
  assign active     = enable && run_s && (reference_source_select != REF_OFF)
                   && (reference_source_select <= REF_COMM_TRIM);
  assign max_tenths = 48'($signed({1'b0, maximum_frequency_setting})) * 48'(FREQ_TENTHS);

  always_comb begin
    err_raw = 32'(reference) - 32'(feedback);
    err_abs = (err_raw < 32'sh0) ? -err_raw : err_raw;
    err     = (err_abs <= 32'($signed({1'b0, error_deadband}))) ? 32'sh0 : err_raw;
    p_term  = (48'(err) * 48'($signed({1'b0, prop_gain})) * 48'($signed({1'b0,
              maximum_frequency_setting}))) / 48'(COMM_PCT_MUL);
    pid_raw = (p_term >>> KP_FRAC) + (acc >>> KI_FRAC);
    if (trim_mode) begin
      lim_hi = 32'($signed({1'b0, trim_hi}));
      lim_lo = -32'($signed({1'b0, trim_lo}));
    end else begin
      lim_hi = max_tenths[31:0];
      lim_lo = 32'sh0;
    end
    pid = pfs_clamp(pid_raw, lim_lo, lim_hi);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      feedback <= PCT_ZERO;
    else if (i_ce)
      feedback <= fb_sel;
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop state and integrator
  pfs_state_e next_state;

  always_comb begin
    case (state)
      ST_IDLE: next_state = active ? ST_LOAD : ST_IDLE;
      ST_LOAD: next_state = active ? ST_RUN : ST_IDLE;
      ST_RUN:  next_state = active ? ST_RUN : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      state <= ST_IDLE;
    else if (i_ce)
      state <= next_state;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc      <= '0;
      at_limit <= 1'b0;
    end else if (i_ce) begin
      at_limit <= (pid_raw > 48'(lim_hi)) || (pid_raw < 48'(lim_lo));
      if (state == ST_LOAD) begin
        acc <= 48'($signed({1'b0, integrator_preload})) <<< KI_FRAC;
      end else if (state == ST_RUN) begin
        // no integration further into a limit
        if (!((pid_raw >= 48'(lim_hi) && err > 32'sh0) ||
              (pid_raw <= 48'(lim_lo) && err < 32'sh0)))
          acc <= acc + 48'(err) * 48'($signed({1'b0, integ_gain}));
      end else begin
        acc <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency command
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_freq_cmd   <= '0;
      o_error      <= '0;
      o_regulating <= 1'b0;
    end else if (i_ce) begin
      o_error      <= 16'(pfs_clamp(48'(err), 32'(PCT_NEG_FULL) * 32'sh2,
                                    32'(PCT_FULL) * 32'sh2));
      o_regulating <= (state == ST_RUN);
      if (state == ST_IDLE)
        o_freq_cmd <= speed_ref;
      else if (trim_mode)
        o_freq_cmd <= 16'(pfs_clamp(48'(speed_ref) + 48'(pid),
                                    -32'sh8000, 32'sh7fff));
      else
        o_freq_cmd <= pid[15:0];
    end
  end

endmodule

// *** pfs_pkg.sv ***
/*
  Shared constants for the regulator front end: register map, control fields,
  selector codes, loop states, fixed-point scales and a saturating helper.
  Assumes percentages in 0.1 % steps, frequencies in 0.1 Hz steps and the maximum frequency in whole hertz.
*/
package pfs_pkg;

  localparam int                 PW           = 16;
  localparam logic signed [15:0] PCT_FULL     = 16'sh03e8;
  localparam logic signed [15:0] PCT_ZERO     = 16'sh0000;
  localparam logic signed [15:0] PCT_NEG_FULL = -16'sh03e8;
  localparam logic signed [31:0] PCT_DIV      = 32'sh0000_03e8;
  localparam logic signed [31:0] COMM_PCT_MUL = 32'sh0000_0064;
  localparam logic signed [31:0] FREQ_TENTHS  = 32'sh0000_000a;
  localparam int                 KP_FRAC      = 8;
  localparam int                 KI_FRAC      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_AN1_LO   = 8'h04;
  localparam logic [7:0] REG_AN1_HI   = 8'h08;
  localparam logic [7:0] REG_AN2_LO   = 8'h0c;
  localparam logic [7:0] REG_AN2_HI   = 8'h10;
  localparam logic [7:0] REG_SETPOINT = 8'h14;
  localparam logic [7:0] REG_DEADBAND = 8'h18;
  localparam logic [7:0] REG_PRELOAD  = 8'h1c;
  localparam logic [7:0] REG_KP       = 8'h20;
  localparam logic [7:0] REG_KI       = 8'h24;
  localparam logic [7:0] REG_TRIM_HI  = 8'h28;
  localparam logic [7:0] REG_TRIM_LO  = 8'h2c;
  localparam logic [7:0] REG_MAX_FREQ = 8'h30;
  localparam logic [7:0] REG_STAT_FB  = 8'h34;
  localparam logic [7:0] REG_STAT_ERR = 8'h38;
  localparam logic [7:0] REG_STAT_CMD = 8'h3c;
  localparam logic [7:0] REG_STATUS   = 8'h40;

  // control register fields
  localparam int CTRL_REF_LSB = 0;
  localparam int CTRL_FB_LSB  = 4;
  localparam int CTRL_EN_BIT  = 8;

  // reset values
  localparam logic [3:0]  RST_SEL      = 4'h0;
  localparam logic [15:0] RST_AN_LO    = 16'h0000;
  localparam logic [15:0] RST_AN_HI    = 16'h03e8;
  localparam logic [15:0] RST_MAX_FREQ = 16'h003c;
  localparam logic [15:0] RST_ZERO16   = 16'h0000;
  localparam logic [15:0] RST_KP       = 16'h0100;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    FB_AN1  = 4'h0,
    FB_AN2  = 4'h1,
    FB_COMM = 4'h2,
    FB_DIFF = 4'h3,
    FB_SUM  = 4'h4,
    FB_PROD = 4'h5,
    FB_QUOT = 4'h6,
    FB_MIN  = 4'h7,
    FB_MAX  = 4'h8
  } pfs_fb_e;

  localparam logic [3:0] REF_OFF        = 4'h0;
  localparam logic [3:0] REF_SETPT      = 4'h1;
  localparam logic [3:0] REF_AN1        = 4'h2;
  localparam logic [3:0] REF_AN2        = 4'h3;
  localparam logic [3:0] REF_COMM       = 4'h4;
  localparam logic [3:0] REF_SETPT_TRIM = 4'h5;
  localparam logic [3:0] REF_AN2_TRIM   = 4'h6;
  localparam logic [3:0] REF_AN1_TRIM   = 4'h7;
  localparam logic [3:0] REF_COMM_TRIM  = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } pfs_state_e;

  // clamp a wide signed value into [lo, hi]
  function automatic logic signed [31:0] pfs_clamp(input logic signed [47:0] v,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
    if (v > 48'(hi)) return hi;
    if (v < 48'(lo)) return lo;
    return v[31:0];
  endfunction

endpackage

// *** pfs_scale.sv ***
/*
  Linear map of one analog reading onto 0..100 % reference between a low and a
  high point; a low point above the high point inverts the map.
  Assumes all values in 0.1 % steps; purely combinational.
*/
`timescale 1ns/100ps
module pfs_scale
  import pfs_pkg::*;
(
  input  wire logic signed [15:0] i_in,
  input  wire logic signed [15:0] i_lo,
  input  wire logic signed [15:0] i_hi,
  output logic signed      [15:0] o_pct
);

  logic signed [31:0] span;
  logic signed [47:0] num;
  logic signed [47:0] quo;

  always_comb begin
    span = 32'(i_hi) - 32'(i_lo);
    num  = (48'(i_in) - 48'(i_lo)) * 48'(PCT_DIV);
    quo  = (span == 32'sh0) ? 48'sh0 : num / 48'(span);
    // negative span gives the inverted map
    o_pct = 16'(pfs_clamp(quo, 32'(PCT_ZERO), 32'(PCT_FULL)));
  end

endmodule

// *** pfs_fb_mux.sv ***
/*
  Feedback source selection and combination of the two actual inputs.
  Assumes inputs in 0.1 % steps, max frequency in whole hertz; combinational.
*/
`timescale 1ns/100ps
module pfs_fb_mux
  import pfs_pkg::*;
(
  input  wire logic        [3:0]  i_sel,
  input  wire logic signed [15:0] i_an_one,
  input  wire logic signed [15:0] i_an_two,
  input  wire logic signed [15:0] i_comm_word,
  input  wire logic        [15:0] i_max_freq,
  input  wire logic signed [15:0] i_actual_one,
  input  wire logic signed [15:0] i_actual_two,
  output logic signed      [15:0] o_fb
);

  logic signed [47:0] a1;
  logic signed [47:0] a2;
  logic signed [47:0] wide;

  always_comb begin
    a1   = 48'(i_actual_one);
    a2   = 48'(i_actual_two);
    wide = 48'sh0;
    case (i_sel)
      FB_AN1:  wide = 48'(i_an_one);
      FB_AN2:  wide = (i_an_two < PCT_ZERO) ? 48'sh0 : 48'(i_an_two);
      FB_COMM: begin
        // ten times max frequency is full scale
        if (i_max_freq == 16'h0)
          wide = 48'(PCT_FULL);
        else
          wide = (48'(i_comm_word) * 48'(COMM_PCT_MUL)) / 48'($signed({1'b0, i_max_freq}));
      end
      FB_DIFF: wide = a1 - a2;
      FB_SUM:  wide = a1 + a2;
      FB_PROD: wide = (a1 * a2) / 48'(PCT_DIV);
      FB_QUOT: begin
        // zero divisor saturates at full scale
        if (a2 == 48'sh0)
          wide = 48'(PCT_FULL);
        else
          wide = (a1 * 48'(PCT_DIV)) / a2;
      end
      FB_MIN:  wide = (a1 < a2) ? a1 : a2;
      FB_MAX:  wide = (a1 > a2) ? a1 : a2;
      default: wide = 48'(i_an_one);
    endcase
    // saturate combined results to the percent range
    o_fb = 16'(pfs_clamp(wide, 32'(PCT_NEG_FULL), 32'(PCT_FULL)));
  end

endmodule

// *** pfs_regulator_assertions.sv ***
/* bus and loop checks on pfs_regulator ports
   assumes bind to pfs_regulator, one clock domain */
`timescale 1ns/100ps
module pfs_regulator_chk
  import pfs_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        i_run,
  input wire logic [15:0] o_freq_cmd,
  input wire logic [15:0] o_error,
  input wire logic        o_regulating
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  rdy_follow_a: assert property (psel && penable && !pready && i_ce |=> pready)
    else $error("pready missing after access");
  rdy_pulse_a: assert property (pready && i_ce |=> !pready)
    else $error("pready longer than one cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdy_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("pready without request");
  err_range_a: assert property ($signed(o_error) <= 2000 && $signed(o_error) >= -2000)
    else $error("error out of range");
  idle_off_a: assert property (!i_run [*8] |-> !o_regulating)
    else $error("regulating without run");
  run_cause_a: assert property ($rose(o_regulating) |-> $past(i_run, 2))
    else $error("regulating rose without run");
  out_hold_a: assert property (!i_ce |=> $stable(o_freq_cmd) && $stable(o_error))
    else $error("outputs moved with enable low");
  data_hold_a: assert property (!i_ce |=> $stable(prdata))
    else $error("read data moved with enable low");
  ////////////////////////////////////////////////////////////////////////////
  err_c: cover property (pslverr);
  run_c: cover property (o_regulating);
  rd_c: cover property (pready && !pwrite);
endmodule

bind pfs_regulator pfs_regulator_chk chk_u (.i_clk, .i_rst_n, .i_ce, .psel, .penable,
  .pwrite, .pready, .pslverr, .prdata, .i_run, .o_freq_cmd, .o_error, .o_regulating);

// *** pfs_sensor_model.sv ***
/* sensor and network word source
   assumes the bench sets the wanted words; one clock delay to the pins */
`timescale 1ns/100ps
module pfs_sensor_model (
  input  wire logic        i_clk,
  input  wire logic [95:0] i_want,
  output logic      [95:0] o_word
);
  always_ff @(posedge i_clk) begin
    o_word <= i_want;
  end
endmodule

// *** tb_pid_feedback_select_deadband_preload.sv ***
/* self-checking bench for pfs_regulator over apb
   assumes the sensor model feeds every sensor and network pin */
`timescale 1ns/100ps
module tb_pid_feedback_select_deadband_preload
  import pfs_pkg::*;
;
  logic        i_clk = 0, i_rst_n = 0, i_ce = 1, i_run = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, o_regulating;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] o_freq_cmd, o_error;
  logic [95:0] want = 0, word;
  logic [33:0] note;
  logic [33:0] note_q[$];
  int          err_total = 0, comparisons = 0, cyc = 0, a1, a2, n1;

  always #5 i_clk = ~i_clk;

  pfs_sensor_model part_u (.i_clk, .i_want(want), .o_word(word));
  pfs_regulator dut_u (.i_clk, .i_rst_n, .i_ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .i_analog_one(word[15:0]), .i_analog_two(word[31:16]),
    .i_actual_one(word[47:32]), .i_actual_two(word[63:48]), .i_comm_word(word[79:64]),
    .i_speed_ref(word[95:80]), .i_run, .o_freq_cmd, .o_error, .o_regulating);

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // one apb transfer; the note holds direction, error and expected data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e = 0);
    @(posedge i_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    note_q.push_back({w, e, d});
    @(posedge i_clk);
    penable <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic settle();
    repeat (10) @(posedge i_clk);
  endtask

  function automatic logic [31:0] fbx(int s, int n1, int a1, int a2);
    int v;
    case (s)
      1: v = 0;
      2: v = 500;
      3: v = a1 - a2;
      4: v = a1 + a2;
      5: v = a1 * a2 / 1000;
      6: v = (a2 == 0) ? 1000 : a1 * 1000 / a2;
      7: v = (a1 < a2) ? a1 : a2;
      8: v = (a1 > a2) ? a1 : a2;
      default: v = n1;
    endcase
    if (v > 1000) v = 1000;
    return {16'h0, v[15:0]};
  endfunction

  always @(posedge i_clk) begin
    if (psel && penable && pready) begin
      note = note_q.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (!note[33]) chk("prdata", prdata, note[31:0]);
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6b5a7a2a));
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1;
    apb(0, REG_CTRL, 0);
    apb(0, REG_KP, 32'h100);
    apb(0, REG_MAX_FREQ, 32'h3c);
    apb(0, REG_AN1_HI, 32'h3e8);
    apb(1, 8'h44, 32'h5, 1);
    i_ce <= 0;
    want <= 96'h1234;
    repeat (4) @(posedge i_clk);
    i_ce <= 1;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 10; s++) begin
        if ((p == 2 && s != 6) || (p == 1 && (s == 5 || s == 6))) continue;
        a1 = (p == 1) ? $urandom_range(900, 100) : 200;
        a2 = (p == 1) ? $urandom_range(900, 100) : (p == 2) ? 0 : 400;
        n1 = $urandom_range(1000, 0);
        want <= {16'h0, 16'd300, 16'(a2), 16'(a1), 16'hffce, 16'(n1)};
        apb(1, REG_CTRL, 32'(s) << 4);
        settle();
        apb(0, REG_STAT_FB, fbx(s, n1, a1, a2));
      end
    end
    apb(1, REG_AN1_LO, 32'd1000);
    apb(1, REG_AN1_HI, 0);
    apb(1, REG_KP, 0);
    want <= 96'd250;
    apb(1, REG_CTRL, 32'h112);
    i_run <= 1;
    settle();
    apb(0, REG_STAT_ERR, 32'd750);
    apb(1, REG_AN1_LO, 0);
    apb(1, REG_AN1_HI, 32'd500);
    settle();
    apb(0, REG_STAT_ERR, 32'd500);
    apb(1, REG_SETPOINT, 32'd250);
    apb(1, REG_DEADBAND, 32'd50);
    apb(1, REG_CTRL, 32'h101);
    want <= 96'd200;
    settle();
    apb(0, REG_STAT_ERR, 0);
    want <= 96'd199;
    settle();
    apb(0, REG_STAT_ERR, 32'd51);
    apb(1, REG_PRELOAD, 32'd500);
    i_run <= 0;
    settle();
    chk("o_regulating", {31'h0, o_regulating}, 0);
    chk("o_freq_cmd", {16'h0, o_freq_cmd}, 0);
    i_run <= 1;
    settle();
    chk("o_regulating", {31'h0, o_regulating}, 1);
    chk("o_freq_cmd", {16'h0, o_freq_cmd}, 32'd500);
    apb(0, REG_STAT_CMD, 32'd500);
    apb(1, REG_STAT_CMD, 32'h7);
    apb(0, REG_STAT_CMD, 32'd500);
    // trim mode: preload 500 clamped to trim high, added to speed 300
    want <= {16'd300, 80'd199};
    apb(1, REG_TRIM_HI, 32'd100);
    apb(1, REG_CTRL, 32'h105);
    settle();
    apb(0, REG_STAT_CMD, 32'd400);
    apb(0, REG_STATUS, 32'h6);
    // large integral gain while pushing into the limit must not wind up
    apb(1, REG_KI, 32'h1000);
    settle();
    apb(1, REG_KI, 0);
    apb(1, REG_TRIM_HI, 32'd1000);
    settle();
    apb(0, REG_STAT_CMD, 32'd800);
    chk("o_freq_cmd", {16'h0, o_freq_cmd}, 32'd800);
    repeat (5) @(posedge i_clk);
    close_out();
  end
endmodule
